// >>> design/sata_pm_pkg.sv
// sata_pm_pkg: constants for the serial ata power and sideband block.
// assumes a 40 mhz core clock and a plain strobe register port.
// Summary of operation
// - never start partial or slumber; acknowledge every drive low-power request on an enabled port outside d3.
// - before using the link, wake it with com_wake if partial or slumber.
// - partial to ready recovery completes within 10 ns.
// - slumber to ready may take up to 10 ms; waiting logic tolerates it.
// - drive standby needs no host action beyond forwarding commands.
// - in d3 only config accesses pass; memory and i/o accesses master abort.
// - in d3 interrupts are suppressed; pending status may interrupt after d0.
// - in d3 port wires hold nothing; ports treated as empty.
// - leaving d3 performs no internal reset; state is preserved.
// - in legacy mode never assert the power-management event.
// - legacy i/o hits on enabled trap ranges are blocked and raise a trap.
// - bus-master register accesses under trap still update, trap, set status.
// - activity led driven low while any port busy, released otherwise.
// - clock request only driven low or released, never high.
// - clock request released only when every link is slumber or disabled.
// - clock power saving only with enable bit set and pin in native function.
// - after reset the clock request is driven low.
// - software may power down a drive and disable its port.
package sata_pm_pkg;
   localparam int          CLK_MHZ          = 40;
   localparam int          PARTIAL_EXIT_NS  = 10;
   localparam int          SLUMBER_EXIT_MS  = 10;
   localparam int          PARTIAL_CYC      = (PARTIAL_EXIT_NS * CLK_MHZ) / 1000 < 1 ? 1
                                              : (PARTIAL_EXIT_NS * CLK_MHZ) / 1000;
   localparam int          SLUMBER_CYC      = SLUMBER_EXIT_MS * CLK_MHZ * 1000;
   // register offsets
   localparam logic [3:0]  REG_CTRL         = 4'h0;
   localparam logic [3:0]  REG_TRAP_EN      = 4'h1;
   localparam logic [3:0]  REG_TRAP_STAT    = 4'h2;
   localparam logic [3:0]  REG_PORT_CFG     = 4'h3;
   localparam logic [3:0]  REG_STATUS       = 4'h4;
   // ctrl fields
   localparam int          CTRL_D3          = 0;
   localparam int          CTRL_LEGACY      = 1;
   localparam int          CTRL_CLKREQ_EN   = 2;
   localparam int          CTRL_NATIVE      = 3;
   localparam logic [31:0] CTRL_RESET       = 32'h0000_0002;
   // trap enable fields
   localparam int          TRAP_PRI         = 0;
   localparam int          TRAP_SEC         = 1;
   // legacy i/o ranges
   localparam logic [15:0] IO_PRI_CMD       = 16'h01f0;
   localparam logic [15:0] IO_PRI_CTL       = 16'h03f6;
   localparam logic [15:0] IO_SEC_CMD       = 16'h0170;
   localparam logic [15:0] IO_SEC_CTL       = 16'h0376;
   // link power state codes
   localparam logic [1:0]  LNK_READY        = 2'h0;
   localparam logic [1:0]  LNK_PARTIAL      = 2'h1;
   localparam logic [1:0]  LNK_SLUMBER      = 2'h2;
   localparam logic [1:0]  LNK_OFF          = 2'h3;
endpackage

// >>> design/sata_power_sideband_control.sv
// sata_power_sideband_control: link power acks, wake, d3 gating, legacy traps,
// activity led and reference clock request.
// assumes one 40 mhz clock; link state and busy bits come from phy domains.
`timescale 1ns/100ps
module sata_power_sideband_control #(
   parameter int NPORTS      = 4,
   parameter int SLUMBER_CYC = sata_pm_pkg::SLUMBER_CYC
) (
   input  wire logic              clock,
   input  wire logic              nrst,
   input  wire logic              clk_en,
   // register port
   input  wire logic [3:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   // link side, per port
   input  wire logic [2*NPORTS-1:0] link_state,
   input  wire logic [NPORTS-1:0] pm_req,
   output logic      [NPORTS-1:0] pm_ack,
   output logic      [NPORTS-1:0] com_wake,
   input  wire logic [NPORTS-1:0] need_link,
   output logic      [NPORTS-1:0] link_ready,
   output logic      [NPORTS-1:0] port_enable,
   output logic      [NPORTS-1:0] port_power,
   input  wire logic [NPORTS-1:0] port_busy,
   // host access filter
   input  wire logic              acc_valid,
   input  wire logic              acc_cfg,
   input  wire logic              acc_io,
   input  wire logic              acc_bm,
   input  wire logic              acc_bm_sec,
   input  wire logic [15:0]       acc_addr,
   output logic                   acc_forward,
   output logic                   acc_abort,
   // interrupt and events
   input  wire logic              core_irq,
   output logic                   irq_out,
   input  wire logic              pme_event,
   input  wire logic              interlock_switch_input,
   output logic                   pme_out,
   output logic                   mgmt_trap_interrupt_n,
   // sideband pins
   output logic                   activity_led_n,
   output logic                   activity_led_oe,
   output logic                   refclk_request_n,
   output logic                   refclk_request_oe
);

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic in_range(input logic [15:0] a, input logic [15:0] base);
      in_range = (a[15:3] == base[15:3]);
   endfunction

   logic [31:0]         ctrl_q;
   logic [1:0]          trap_en_q;
   logic [1:0]          trap_stat_q;
   logic [NPORTS-1:0]   port_en_q;
   logic [NPORTS-1:0]   port_pwr_q;
   logic [2*NPORTS-1:0] lnk_s1_q;
   logic [2*NPORTS-1:0] lnk_q;
   logic [NPORTS-1:0]   busy_s1_q;
   logic [NPORTS-1:0]   busy_q;
   logic [NPORTS-1:0]   req_s1_q;
   logic [NPORTS-1:0]   req_q;
   logic [NPORTS-1:0]   need_s1_q;
   logic [NPORTS-1:0]   need_q;
   logic [1:0]          sw_s1_q;
   logic                trap_pulse_q;
   logic                refclk_rel_q;
   logic                d3;
   logic                legacy;
   logic                hit_pri;
   logic                hit_sec;
   logic                trap_hit;
   logic [1:0]          trap_set;

   assign d3     = ctrl_q[sata_pm_pkg::CTRL_D3];
   assign legacy = ctrl_q[sata_pm_pkg::CTRL_LEGACY];

   ////////////////////////////////////////////////////////////////////////////
   // two-flop synchronisers; only the second stage is read, except sw_s1_q, a single sampling stage
   always_ff @(posedge clock) begin
      if (!nrst) begin
         lnk_s1_q  <= '0;
         lnk_q     <= '0;
         busy_s1_q <= '0;
         busy_q    <= '0;
         req_s1_q  <= '0;
         req_q     <= '0;
         need_s1_q <= '0;
         need_q    <= '0;
         sw_s1_q   <= '0;
      end else if (clk_en) begin
         lnk_s1_q  <= link_state;
         lnk_q     <= lnk_s1_q;
         busy_s1_q <= port_busy;
         busy_q    <= busy_s1_q;
         req_s1_q  <= pm_req;
         req_q     <= req_s1_q;
         need_s1_q <= need_link;
         need_q    <= need_s1_q;
         sw_s1_q   <= {interlock_switch_input, pme_event};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers; d3 exit never resets anything, only nrst does
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ctrl_q     <= sata_pm_pkg::CTRL_RESET;
         trap_en_q  <= '0;
         port_en_q  <= '1;
         port_pwr_q <= '1;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == sata_pm_pkg::REG_CTRL) begin
            ctrl_q <= {28'h0000000, reg_wdata[3:0]};
         end else if (reg_addr == sata_pm_pkg::REG_TRAP_EN) begin
            trap_en_q <= reg_wdata[1:0];
         end else if (reg_addr == sata_pm_pkg::REG_PORT_CFG) begin
            port_en_q  <= reg_wdata[NPORTS-1:0];
            port_pwr_q <= reg_wdata[NPORTS+7:8];
         end
      end
   end

   // port wires idle in d3, ports look empty
   assign port_enable = d3 ? '0 : port_en_q;
   assign port_power  = d3 ? '0 : port_pwr_q;

   ////////////////////////////////////////////////////////////////////////////
   // access filter and legacy traps
   assign hit_pri  = trap_en_q[sata_pm_pkg::TRAP_PRI] &&
                     (in_range(acc_addr, sata_pm_pkg::IO_PRI_CMD) || acc_addr == sata_pm_pkg::IO_PRI_CTL);
   assign hit_sec  = trap_en_q[sata_pm_pkg::TRAP_SEC] &&
                     (in_range(acc_addr, sata_pm_pkg::IO_SEC_CMD) || acc_addr == sata_pm_pkg::IO_SEC_CTL);
   assign trap_set[0] = acc_valid && legacy && !d3 &&
                        ((acc_io && !acc_bm && hit_pri) ||
                         (acc_bm && !acc_bm_sec && trap_en_q[sata_pm_pkg::TRAP_PRI]));
   assign trap_set[1] = acc_valid && legacy && !d3 &&
                        ((acc_io && !acc_bm && hit_sec) ||
                         (acc_bm && acc_bm_sec && trap_en_q[sata_pm_pkg::TRAP_SEC]));
   assign trap_hit = |trap_set;

   // bus-master accesses still pass on a trap, task file accesses do not
   assign acc_abort   = acc_valid && d3 && !acc_cfg;
   assign acc_forward = acc_valid && !acc_abort &&
                        !(acc_io && !acc_bm && trap_hit);

   always_ff @(posedge clock) begin
      if (!nrst) begin
         trap_stat_q  <= '0;
         trap_pulse_q <= 1'b0;
      end else if (clk_en) begin
         trap_pulse_q <= trap_hit;
         // set wins over a clear in the same cycle
         if (reg_wr && reg_addr == sata_pm_pkg::REG_TRAP_STAT) begin
            trap_stat_q <= (trap_stat_q & ~reg_wdata[1:0]) | trap_set;
         end else begin
            trap_stat_q <= trap_stat_q | trap_set;
         end
      end
   end

   assign mgmt_trap_interrupt_n = !trap_pulse_q;

   ////////////////////////////////////////////////////////////////////////////
   // interrupt and power events
   assign irq_out = core_irq && !d3;
   // no event path in any mode: attach and switch events never raise the event line
   assign pme_out = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // link power: ack drive requests, wake on demand
   genvar p;
   generate
      for (p = 0; p < NPORTS; p++) begin : g_port
         logic [31:0] wait_q;
         logic        wake_q;
         logic        ack_q;
         logic [1:0]  st;
         logic        low;
         assign st  = lnk_q[2*p+1:2*p];
         assign low = (st == sata_pm_pkg::LNK_PARTIAL) || (st == sata_pm_pkg::LNK_SLUMBER);
         always_ff @(posedge clock) begin
            if (!nrst) begin
               ack_q  <= 1'b0;
               wake_q <= 1'b0;
               wait_q <= '0;
            end else if (clk_en) begin
               ack_q <= req_q[p] && port_en_q[p] && !d3;
               if (need_q[p] && low && !wake_q && !d3) begin
                  wake_q <= 1'b1;
                  wait_q <= '0;
               end else if (wake_q) begin
                  if (st == sata_pm_pkg::LNK_READY || wait_q == 32'(SLUMBER_CYC)) begin
                     wake_q <= 1'b0;
                  end else begin
                     wait_q <= wait_q + 32'h1;
                  end
               end
            end
         end
         assign pm_ack[p]     = ack_q;
         assign com_wake[p]   = wake_q;
         assign link_ready[p] = (st == sata_pm_pkg::LNK_READY) && port_en_q[p] && !d3;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // activity led and clock request, open drain style
   logic all_idle;
   always_comb begin
      all_idle = 1'b1;
      for (int i = 0; i < NPORTS; i++) begin
         if (lnk_q[2*i+:2] != sata_pm_pkg::LNK_SLUMBER && lnk_q[2*i+:2] != sata_pm_pkg::LNK_OFF &&
             port_en_q[i] && !d3) begin
            all_idle = 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         refclk_rel_q <= 1'b0;
      end else if (clk_en) begin
         refclk_rel_q <= all_idle && ctrl_q[sata_pm_pkg::CTRL_CLKREQ_EN] &&
                         ctrl_q[sata_pm_pkg::CTRL_NATIVE] && !(|com_wake);
      end
   end

   assign refclk_request_n  = 1'b0;
   assign refclk_request_oe = !refclk_rel_q;
   assign activity_led_n    = 1'b0;
   assign activity_led_oe   = |busy_q;

   ////////////////////////////////////////////////////////////////////////////
   // register read, data one cycle after the strobe
   always_ff @(posedge clock) begin
      if (!nrst) begin
         reg_rdata <= '0;
      end else if (clk_en) begin
         if (!reg_rd) begin
            reg_rdata <= '0;
         end else if (reg_addr == sata_pm_pkg::REG_CTRL) begin
            reg_rdata <= ctrl_q;
         end else if (reg_addr == sata_pm_pkg::REG_TRAP_EN) begin
            reg_rdata <= {30'h0, trap_en_q};
         end else if (reg_addr == sata_pm_pkg::REG_TRAP_STAT) begin
            reg_rdata <= {30'h0, trap_stat_q};
         end else if (reg_addr == sata_pm_pkg::REG_PORT_CFG) begin
            reg_rdata <= 32'({port_pwr_q, 8'(port_en_q)});
         end else if (reg_addr == sata_pm_pkg::REG_STATUS) begin
            reg_rdata <= 32'({lnk_q, 8'(busy_q), 7'h0, refclk_rel_q});
         end else begin
            reg_rdata <= '0;
         end
      end
   end

   // unused event inputs, kept sampled for a later native-mode event path
   logic unused_sw;
   assign unused_sw = ^sw_s1_q;

endmodule

// >>> sim/sata_pm_monitor.sv
// sata_pm_monitor: port checks for the power and sideband block.
// assumes clk_en held high and a bind onto the block top.
`timescale 1ns/100ps
module sata_pm_monitor #(
   parameter int NPORTS      = 4,
   parameter int SLUMBER_CYC = 50
) (
   input wire logic [2*NPORTS-1:0] link_state,
   input wire logic [NPORTS-1:0]   pm_req,
   input wire logic [NPORTS-1:0]   pm_ack,
   input wire logic [NPORTS-1:0]   com_wake,
   input wire logic [NPORTS-1:0]   need_link,
   input wire logic [NPORTS-1:0]   port_busy,
   input wire logic                clock,
   input wire logic                nrst,
   input wire logic                acc_valid,
   input wire logic                acc_cfg,
   input wire logic                acc_io,
   input wire logic                acc_bm,
   input wire logic                acc_forward,
   input wire logic                acc_abort,
   input wire logic                irq_out,
   input wire logic                pme_out,
   input wire logic                mgmt_trap_interrupt_n,
   input wire logic                activity_led_oe,
   input wire logic                refclk_request_n,
   input wire logic                refclk_request_oe
);
   logic [NPORTS-1:0] idle_w;
   int                wake_q;
   for (genvar i = 0; i < NPORTS; i++) begin : g_idle
      assign idle_w[i] = link_state[2*i+1];
   end
   // counts one continuous wake; overlapping wakes are not covered
   always_ff @(posedge clock) begin
      if (!nrst || com_wake == '0)
         wake_q <= 0;
      else
         wake_q <= wake_q + 1;
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   chk_ack_req: assert property ($rose(pm_req[0]) |-> ##[1:4] pm_ack[0])
      else $error("low-power request not acknowledged");
   chk_wake_start: assert property ($rose(need_link[0]) && link_state[1:0] == sata_pm_pkg::LNK_SLUMBER
      |-> ##[1:4] com_wake[0]) else $error("no wake for a sleeping link");
   chk_wake_bound: assert property (wake_q <= SLUMBER_CYC + 8)
      else $error("wake held past its timeout");
   chk_cfg_pass: assert property (acc_valid && acc_cfg |-> acc_forward && !acc_abort)
      else $error("config access not forwarded");
   chk_d3_quiet: assert property (acc_abort |-> !irq_out && !acc_cfg)
      else $error("abort with interrupt or on config");
   chk_pme_never: assert property (pme_out == 1'h0)
      else $error("power event raised");
   chk_trap_cause: assert property (!mgmt_trap_interrupt_n
      |-> $past(acc_valid && (acc_bm || acc_io && !acc_forward))) else $error("trap without cause");
   chk_trap_pulse: assert property ($fell(mgmt_trap_interrupt_n) |=> mgmt_trap_interrupt_n)
      else $error("trap pulse too long");
   chk_led_busy: assert property ((|port_busy) [*4] |-> activity_led_oe)
      else $error("led not driven while busy");
   chk_led_idle: assert property ((port_busy == '0) [*4] |-> !activity_led_oe)
      else $error("led driven while idle");
   chk_clkreq_low: assert property (refclk_request_n == 1'h0)
      else $error("clock request driven high");
   chk_clkreq_idle: assert property ($fell(refclk_request_oe) |-> $past(&idle_w))
      else $error("clock request released with a link awake");
   chk_clkreq_reset: assert property ($rose(nrst) |-> refclk_request_oe)
      else $error("clock request not driven after reset");
endmodule

// >>> sim/sata_drive_model.sv
// sata_drive_model: one attached drive; asks for slumber, wakes on request.
// assumes ack and wake from the block are levels on the core clock.
`timescale 1ns/100ps
module sata_drive_model #(
   parameter int WAKE_CYC = 4
) (
   input wire logic  clock,
   input wire logic  nrst,
   input wire logic  want_low,
   input wire logic  com_wake,
   input wire logic  pm_ack,
   output logic [1:0] link_state,
   output logic      pm_req
);
   int cnt;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         link_state <= sata_pm_pkg::LNK_READY;
         pm_req <= 1'h0;
         cnt <= 0;
      end else if (com_wake && link_state != sata_pm_pkg::LNK_READY) begin
         // a slow drive outlasts the host timeout on purpose
         cnt <= cnt + 1;
         if (cnt == WAKE_CYC)
            link_state <= sata_pm_pkg::LNK_READY;
      end else begin
         cnt <= 0;
         pm_req <= want_low && link_state == sata_pm_pkg::LNK_READY;
         if (pm_req && pm_ack)
            link_state <= sata_pm_pkg::LNK_SLUMBER;
      end
   end
endmodule

// >>> sim/sata_power_sideband_control_tb_top.sv
// sata_power_sideband_control_tb_top: directed bench for the power block.
// assumes two ports, a 50 cycle slumber timeout and clk_en held high.
`timescale 1ns/100ps
module sata_power_sideband_control_tb_top;
   localparam int N = 2;
   logic         clock = 1'h0, nrst = 1'h0, clk_en = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
   logic [3:0]   reg_addr = '0, link_state;
   logic [31:0]  reg_wdata = '0, reg_rdata;
   logic [N-1:0] need_link = '0, port_busy = '0, want_low = '0;
   logic [N-1:0] pm_req, pm_ack, com_wake, link_ready, port_enable, port_power;
   logic         acc_valid = 1'h0, acc_cfg = 1'h0, acc_io = 1'h0, acc_bm = 1'h0, acc_bm_sec = 1'h0;
   logic [15:0]  acc_addr = '0;
   logic         core_irq = 1'h0, pme_event = 1'h1, interlock_switch_input = 1'h1;
   logic         acc_forward, acc_abort, irq_out, pme_out, mgmt_trap_interrupt_n;
   logic         activity_led_n, activity_led_oe, refclk_request_n, refclk_request_oe;
   int           n_fail = 0, num_checks = 0;
   wire [3:0]    watch = {com_wake, activity_led_oe, refclk_request_oe};
   sata_power_sideband_control #(.NPORTS(N), .SLUMBER_CYC(50)) u_dut (.*);
   for (genvar i = 0; i < N; i++) begin : g_drv
      sata_drive_model #(.WAKE_CYC(i ? 200 : 4)) u_drv (.clock, .nrst, .want_low(want_low[i]),
         .com_wake(com_wake[i]), .pm_ack(pm_ack[i]), .link_state(link_state[2*i+:2]), .pm_req(pm_req[i]));
   end
   always #12.5 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clock);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'h0;
      #1 chk(reg_rdata, exp);
   endtask
   // forward/abort sampled in the access cycle, trap pulse one cycle later
   task automatic acc(input logic io, input logic bm, input logic [15:0] a, input logic [1:0] fa,
                      input logic trap);
      @(posedge clock);
      acc_valid <= 1'h1;
      acc_io <= io;
      acc_cfg <= !io;
      acc_bm <= bm;
      acc_addr <= a;
      #1 chk({acc_forward, acc_abort}, fa);
      @(posedge clock);
      acc_valid <= 1'h0;
      #1 chk(mgmt_trap_interrupt_n, !trap);
   endtask
   // bounded wait; running out counts as a mismatch and ends the run
   task automatic wait_sig(input int i, input logic v);
      int k;
      for (k = 0; k < 400 && watch[i] !== v; k++)
         @(posedge clock) #1;
      chk(watch[i], v);
      if (k == 400)
         print_verdict();
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clock);
      nrst <= 1'h1;
      @(posedge clock) #1 chk(refclk_request_oe, 1'h1);
      rd(4'h0, sata_pm_pkg::CTRL_RESET);
      rd(4'h3, 32'h303);
      rd(4'hf, 32'h0);
      @(posedge clock) port_busy <= 2'h2;
      wait_sig(1, 1'h1);
      @(posedge clock) port_busy <= 2'h0;
      wait_sig(1, 1'h0);
      @(posedge clock) want_low <= 2'h3;
      repeat (30) @(posedge clock);
      #1 chk(link_state, 32'ha);
      chk(refclk_request_oe, 1'h1);
      wr(4'h0, 32'he);
      wait_sig(0, 1'h0);
      @(posedge clock) want_low <= 2'h0;
      @(posedge clock) need_link <= 2'h1;
      wait_sig(2, 1'h1);
      wait_sig(0, 1'h1);
      wait_sig(2, 1'h0);
      chk(link_state, 32'h8);
      @(posedge clock) need_link <= 2'h3;
      wait_sig(3, 1'h1);
      wait_sig(3, 1'h0);
      chk(link_state, 32'h8);
      @(posedge clock) need_link <= 2'h0;
      wr(4'h1, 32'h3);
      acc(1'h1, 1'h0, 16'h01f3, 2'h0, 1'h1);
      rd(4'h2, 32'h1);
      acc(1'h1, 1'h0, 16'h0376, 2'h0, 1'h1);
      acc(1'h1, 1'h0, 16'h0200, 2'h2, 1'h0);
      wr(4'h2, 32'h1);
      rd(4'h2, 32'h2);
      acc(1'h1, 1'h1, 16'h0c02, 2'h2, 1'h1);
      rd(4'h2, 32'h3);
      wr(4'h0, 32'h3);
      @(posedge clock) core_irq <= 1'h1;
      #1 chk({irq_out, port_enable}, 32'h0);
      acc(1'h1, 1'h0, 16'h01f0, 2'h1, 1'h0);
      acc(1'h0, 1'h0, 16'h0010, 2'h2, 1'h0);
      wr(4'h0, 32'h2);
      #1 chk({irq_out, port_enable}, 32'h7);
      rd(4'h3, 32'h303);
      wr(4'h3, 32'h1);
      #1 chk({port_power, port_enable}, 32'h1);
      chk(pme_out, 1'h0);
      rd(4'h4, 32'h0008_0000);
      @(posedge clock) nrst <= 1'h0;
      repeat (3) @(posedge clock);
      nrst <= 1'h1;
      @(posedge clock) #1 chk(refclk_request_oe, 1'h1);
      rd(4'h0, sata_pm_pkg::CTRL_RESET);
      rd(4'h3, 32'h303);
      print_verdict();
   end
endmodule
bind sata_power_sideband_control sata_pm_monitor #(.NPORTS(NPORTS), .SLUMBER_CYC(SLUMBER_CYC)) u_mon (.*);
